// ---- include/sfisr_pkg.sv ----
// sfisr_pkg: opcodes, status layout, frame lengths, ids and timing
// assumes: one serial byte per 8 link clock edges, msb first
package sfisr_pkg;
   // opcodes
   localparam logic [7:0] OP_ID    = 8'h9f;
   localparam logic [7:0] OP_SIG   = 8'hab;
   localparam logic [7:0] OP_PAIR  = 8'h90;
   localparam logic [7:0] OP_STAT  = 8'h05;
   localparam logic [7:0] OP_CFG   = 8'h15;
   localparam logic [7:0] OP_WRITE_ENABLE_CMD  = 8'h06;
   localparam logic [7:0] OP_WRDI  = 8'h04;
   localparam logic [7:0] OP_WSR   = 8'h01;
   localparam logic [7:0] OP_PP    = 8'h02;
   localparam logic [7:0] OP_SE    = 8'h20;
   localparam logic [7:0] OP_BE    = 8'hd8;
   localparam logic [7:0] OP_BE32  = 8'h52;
   localparam logic [7:0] OP_CE    = 8'h60;
   localparam logic [7:0] OP_CE2   = 8'hc7;
   localparam logic [7:0] PAIR_MFR_FIRST = 8'h00;
   localparam logic [7:0] PAIR_DEV_FIRST = 8'h01;
   // status bit positions
   localparam int ST_BUSY  = 0;
   localparam int ST_WEL   = 1;
   localparam int ST_BP_LO = 2;
   localparam int ST_BP_HI = 5;
   localparam int ST_QE    = 6;
   localparam int ST_STATUS_WRITE_DISABLE  = 7;
   // reset values
   localparam logic [7:0] NV_STAT_RST = 8'h00;
   localparam logic [7:0] CFG_RST     = 8'h00;
   // frame lengths in link clock edges
   localparam int CNT_W = 12;
   localparam logic [11:0] LEN_CMD    = 12'h008;
   localparam logic [11:0] LEN_ADDR   = 12'h020;
   localparam logic [11:0] LEN_WSR1   = 12'h010;
   localparam logic [11:0] LEN_WSR2   = 12'h018;
   localparam logic [11:0] LEN_PP_MIN = 12'h028;
   localparam logic [11:0] SHORT_LAST = 12'h007;
   localparam logic [11:0] LONG_LAST  = 12'h01f;
   // identity values, arbitrary
   localparam logic [7:0] MFR_ID_DEF   = 8'h5a;
   localparam logic [7:0] MEM_TYPE_DEF = 8'h3c;
   localparam logic [7:0] DENSITY_DEF  = 8'h15;
   localparam logic [7:0] SIG_DEF      = 8'h3c;
   // busy durations in system clocks
   localparam int BUSY_W = 16;
   localparam logic [15:0] PGM_CYC = 16'h00c8;
   localparam logic [15:0] ERS_CYC = 16'h0190;
   localparam logic [15:0] WSR_CYC = 16'h0064;
   // protection: 64k blocks counted down from the top
   localparam logic [5:0] PROT_TOP = 6'h20;
   typedef enum {ST_IDLE, ST_PGM, ST_WSR} sfisr_op_st_t;
endpackage : sfisr_pkg

// ---- core/sfisr_top.sv ----
// sfisr_top: id, signature and register read slice of a serial flash,
// plus status bits and write gating around an external array engine
// assumes: SCLK_I only toggles while CS_N_I is low (mode 0), and at
// least a few system clocks pass between frames
`timescale 1ns/1ns

module sfisr_top #(
   parameter logic [7:0]  MFR_ID   = sfisr_pkg::MFR_ID_DEF,
   parameter logic [7:0]  MEM_TYPE = sfisr_pkg::MEM_TYPE_DEF,
   parameter logic [7:0]  DENSITY  = sfisr_pkg::DENSITY_DEF,
   parameter logic [7:0]  SIG_ID   = sfisr_pkg::SIG_DEF,
   parameter logic [15:0] PGM_CYCLES = sfisr_pkg::PGM_CYC,
   parameter logic [15:0] ERS_CYCLES = sfisr_pkg::ERS_CYC,
   parameter logic [15:0] WSR_CYCLES = sfisr_pkg::WSR_CYC
) (
   // system
   input  wire logic       SYS_CLK_I,
   input  wire logic       RST_I,
   // serial link
   input  wire logic       SCLK_I,
   input  wire logic       CS_N_I,
   input  wire logic       SI_I,
   output logic            SO_O,
   output logic            SO_OE_O,
   // pin functions of io2 and io3
   input  wire logic       WP_N_I,
   input  wire logic       HOLD_N_I,
   output logic            IO23_DATA_MODE_O,
   output logic            HOLD_ACTIVE_O,
   // status
   output logic [7:0]      STATUS_O
);
   localparam int CW = sfisr_pkg::CNT_W;

   function automatic logic prot_hit(input logic [23:0] a,
                                     input logic [3:0]  bp);
      logic [5:0] blk;
      blk = {1'b0, a[20:16]};
      prot_hit = (bp != 4'h0) &&
                 ((blk + {2'b00, bp}) >= sfisr_pkg::PROT_TOP);
   endfunction : prot_hit

   // link side: cs high acts as reset for frame state
   logic          link_rst;
   logic [CW-1:0] bit_cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic [CW-1:0] last_cnt_r;
   logic [7:0]    shift_r;
   logic [7:0]    cmd_nxt;
   logic [7:0]    op_r;
   logic [7:0]    b1_r;
   logic [7:0]    b2_r;
   logic [7:0]    b3_r;
   logic          frame_tgl_r;
   logic [15:0]   reg_s1_r;
   logic [15:0]   reg_s2_r;
   logic          busy_l;
   logic [47:0]   tx_r;
   logic [47:0]   tx_pat;
   logic          tx_load;
   logic          tx_vld_r;
   logic          so_r;
   logic          so_oe_r;
   // status and config bytes are read by the link side below
   logic [7:0]    cfg_r;
   logic [7:0]    stat_r;

   assign link_rst = RST_I | CS_N_I;
   assign cnt_nxt  = (&bit_cnt_r) ? bit_cnt_r : bit_cnt_r + 1'b1;
   // only io0 is sampled; io3:1 never enter the shifter
   assign cmd_nxt  = {shift_r[6:0], SI_I};
   assign busy_l   = reg_s2_r[sfisr_pkg::ST_BUSY];

   always_ff @(posedge SCLK_I or posedge link_rst) begin
      if (link_rst) begin
         bit_cnt_r <= '0;
      end else begin
         bit_cnt_r <= cnt_nxt;
      end
   end

   // frame capture survives deselect so the system side can decode it
   always_ff @(posedge SCLK_I or posedge RST_I) begin
      if (RST_I) begin
         last_cnt_r <= '0;
         shift_r    <= 8'h00;
      end else begin
         last_cnt_r <= cnt_nxt;
         shift_r    <= cmd_nxt;
      end
   end

   always_ff @(posedge SCLK_I or posedge RST_I) begin
      if (RST_I) begin
         op_r <= 8'h00;
         b1_r <= 8'h00;
         b2_r <= 8'h00;
         b3_r <= 8'h00;
      end else begin
         if (bit_cnt_r == sfisr_pkg::SHORT_LAST) begin
            op_r <= cmd_nxt;
         end
         if (bit_cnt_r == 12'h00f) begin
            b1_r <= cmd_nxt;
         end
         if (bit_cnt_r == 12'h017) begin
            b2_r <= cmd_nxt;
         end
         if (bit_cnt_r == sfisr_pkg::LONG_LAST) begin
            b3_r <= cmd_nxt;
         end
      end
   end

   // one toggle per frame tells the system side a new frame exists
   always_ff @(posedge SCLK_I or posedge RST_I) begin
      if (RST_I) begin
         frame_tgl_r <= 1'b0;
      end else if (bit_cnt_r == '0) begin
         frame_tgl_r <= ~frame_tgl_r;
      end
   end

   // register bytes into link domain; busy and wel bits can also fall inside a frame when an operation finishes
   always_ff @(posedge SCLK_I or posedge RST_I) begin
      if (RST_I) begin
         reg_s1_r <= 16'h0000;
         reg_s2_r <= 16'h0000;
      end else begin
         reg_s1_r <= {cfg_r, stat_r};
         reg_s2_r <= reg_s1_r;
      end
   end

   // 48-bit ring holds whole repeats of 8, 16 and 24 bit answers
   always_comb begin
      tx_load = 1'b0;
      tx_pat  = '0;
      if (bit_cnt_r == sfisr_pkg::SHORT_LAST) begin
         case (cmd_nxt)
            sfisr_pkg::OP_ID: begin
               if (!busy_l) begin
                  tx_load = 1'b1;
                  tx_pat  = {2{MFR_ID, MEM_TYPE, DENSITY}};
               end
            end
            sfisr_pkg::OP_STAT: begin
               tx_load = 1'b1;
               tx_pat  = {6{reg_s2_r[7:0]}};
            end
            sfisr_pkg::OP_CFG: begin
               tx_load = 1'b1;
               tx_pat  = {6{reg_s2_r[15:8]}};
            end
            default: begin
               tx_load = 1'b0;
            end
         endcase
      end else if (bit_cnt_r == sfisr_pkg::LONG_LAST) begin
         case (op_r)
            sfisr_pkg::OP_SIG: begin
               tx_load = 1'b1;
               tx_pat  = {6{SIG_ID}};
            end
            sfisr_pkg::OP_PAIR: begin
               tx_load = 1'b1;
               if (cmd_nxt[0]) begin
                  tx_pat = {3{MEM_TYPE, MFR_ID}};
               end else begin
                  tx_pat = {3{MFR_ID, MEM_TYPE}};
               end
            end
            default: begin
               tx_load = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge SCLK_I or posedge link_rst) begin
      if (link_rst) begin
         tx_r <= '0;
      end else if (tx_load) begin
         tx_r <= tx_pat;
      end else begin
         tx_r <= {tx_r[46:0], tx_r[47]};
      end
   end

   always_ff @(posedge SCLK_I or posedge link_rst) begin
      if (link_rst) begin
         tx_vld_r <= 1'b0;
      end else if (tx_load) begin
         tx_vld_r <= 1'b1;
      end
   end

   // data changes on falling edges, msb first
   always_ff @(negedge SCLK_I or posedge link_rst) begin
      if (link_rst) begin
         so_r    <= 1'b0;
         so_oe_r <= 1'b0;
      end else begin
         so_r    <= tx_r[47];
         so_oe_r <= tx_vld_r;
      end
   end

   assign SO_O    = so_r;
   assign SO_OE_O = so_oe_r;

   // system side
   logic                  cs_s1_r;
   logic                  cs_s2_r;
   logic                  cs_s3_r;
   logic                  tgl_s1_r;
   logic                  tgl_s2_r;
   logic                  seen_r;
   logic                  wp_s1_r;
   logic                  wp_s2_r;
   logic                  hold_s1_r;
   logic                  hold_s2_r;
   logic                  frame_end;
   sfisr_pkg::sfisr_op_st_t state_r;
   logic [15:0]           busy_cnt_r;
   logic                  busy_r;
   logic                  wel_r;
   logic                  status_write_disable_r;
   logic                  qe_r;
   logic [3:0]            bp_r;
   logic                  hold_act_r;
   logic                  idle;
   logic                  hardware_protected_mode;
   logic                  is_pp;
   logic                  is_se;
   logic                  is_ce;
   logic                  is_wsr;
   logic                  prot;
   logic                  pe_cmd;
   logic                  pe_start;
   logic                  pe_reject;
   logic                  wsr_start;
   logic                  done;

   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cs_s1_r   <= 1'b1;
         cs_s2_r   <= 1'b1;
         cs_s3_r   <= 1'b1;
         tgl_s1_r  <= 1'b0;
         tgl_s2_r  <= 1'b0;
         wp_s1_r   <= 1'b1;
         wp_s2_r   <= 1'b1;
         hold_s1_r <= 1'b1;
         hold_s2_r <= 1'b1;
      end else begin
         cs_s1_r   <= CS_N_I;
         cs_s2_r   <= cs_s1_r;
         cs_s3_r   <= cs_s2_r;
         tgl_s1_r  <= frame_tgl_r;
         tgl_s2_r  <= tgl_s1_r;
         wp_s1_r   <= WP_N_I;
         wp_s2_r   <= wp_s1_r;
         hold_s1_r <= HOLD_N_I;
         hold_s2_r <= hold_s1_r;
      end
   end

   // frame registers are stable here: link clock is idle after deselect
   assign frame_end = cs_s2_r & ~cs_s3_r & (tgl_s2_r != seen_r);
   assign idle      = (state_r == sfisr_pkg::ST_IDLE);
   assign hardware_protected_mode       = status_write_disable_r & ~qe_r & ~wp_s2_r;
   assign is_pp     = (op_r == sfisr_pkg::OP_PP) &&
                      (last_cnt_r >= sfisr_pkg::LEN_PP_MIN) &&
                      (last_cnt_r[2:0] == 3'h0);
   assign is_se     = ((op_r == sfisr_pkg::OP_SE) ||
                       (op_r == sfisr_pkg::OP_BE) ||
                       (op_r == sfisr_pkg::OP_BE32)) &&
                      (last_cnt_r == sfisr_pkg::LEN_ADDR);
   assign is_ce     = ((op_r == sfisr_pkg::OP_CE) ||
                       (op_r == sfisr_pkg::OP_CE2)) &&
                      (last_cnt_r == sfisr_pkg::LEN_CMD);
   assign is_wsr    = (op_r == sfisr_pkg::OP_WSR) &&
                      ((last_cnt_r == sfisr_pkg::LEN_WSR1) ||
                       (last_cnt_r == sfisr_pkg::LEN_WSR2));
   assign pe_cmd    = is_pp | is_se | is_ce;
   assign prot      = is_ce ? (bp_r != 4'h0)
                            : prot_hit({b1_r, b2_r, b3_r}, bp_r);
   assign pe_start  = frame_end & idle & wel_r & pe_cmd & ~prot;
   assign pe_reject = frame_end & idle & wel_r & pe_cmd & prot;
   assign wsr_start = frame_end & idle & wel_r & is_wsr & ~hardware_protected_mode;
   assign done      = ~idle & (busy_cnt_r == 16'h0001);

   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         seen_r <= 1'b0;
      end else if (frame_end) begin
         seen_r <= tgl_s2_r;
      end
   end

   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state_r    <= sfisr_pkg::ST_IDLE;
         busy_cnt_r <= 16'h0000;
         busy_r     <= 1'b0;
      end else begin
         case (state_r)
            sfisr_pkg::ST_IDLE: begin
               if (pe_start) begin
                  state_r    <= sfisr_pkg::ST_PGM;
                  busy_cnt_r <= is_pp ? PGM_CYCLES : ERS_CYCLES;
                  busy_r     <= 1'b1;
               end else if (wsr_start) begin
                  state_r    <= sfisr_pkg::ST_WSR;
                  busy_cnt_r <= WSR_CYCLES;
                  busy_r     <= 1'b1;
               end
            end
            sfisr_pkg::ST_PGM, sfisr_pkg::ST_WSR: begin
               busy_cnt_r <= busy_cnt_r - 16'h0001;
               if (done) begin
                  state_r <= sfisr_pkg::ST_IDLE;
                  busy_r  <= 1'b0;
               end
            end
            default: begin
               state_r <= sfisr_pkg::ST_IDLE;
               busy_r  <= 1'b0;
            end
         endcase
      end
   end

   // write commands are ignored while busy; of the reads only id is
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         wel_r <= 1'b0;
      end else if (done || pe_reject) begin
         wel_r <= 1'b0;
      end else if (frame_end && idle &&
                   (op_r == sfisr_pkg::OP_WRDI) &&
                   (last_cnt_r == sfisr_pkg::LEN_CMD)) begin
         wel_r <= 1'b0;
      end else if (frame_end && idle &&
                   (op_r == sfisr_pkg::OP_WRITE_ENABLE_CMD) &&
                   (last_cnt_r == sfisr_pkg::LEN_CMD)) begin
         wel_r <= 1'b1;
      end
   end

   // non-volatile bits: reset models the erased default
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         status_write_disable_r <= sfisr_pkg::NV_STAT_RST[sfisr_pkg::ST_STATUS_WRITE_DISABLE];
         qe_r   <= sfisr_pkg::NV_STAT_RST[sfisr_pkg::ST_QE];
         bp_r   <= sfisr_pkg::NV_STAT_RST[5:2];
         cfg_r  <= sfisr_pkg::CFG_RST;
      end else if (wsr_start) begin
         status_write_disable_r <= b1_r[sfisr_pkg::ST_STATUS_WRITE_DISABLE];
         qe_r   <= b1_r[sfisr_pkg::ST_QE];
         bp_r   <= b1_r[sfisr_pkg::ST_BP_HI:sfisr_pkg::ST_BP_LO];
         if (last_cnt_r == sfisr_pkg::LEN_WSR2) begin
            cfg_r <= b2_r;
         end
      end
   end

   always_comb begin
      stat_r = {status_write_disable_r, qe_r, bp_r, wel_r, busy_r};
   end

   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         hold_act_r <= 1'b0;
      end else begin
         hold_act_r <= ~qe_r & ~hold_s2_r;
      end
   end

   assign IO23_DATA_MODE_O = qe_r;
   assign HOLD_ACTIVE_O    = hold_act_r;
   assign STATUS_O         = stat_r;

   // checks
   sequence s_id_cmd;
      (bit_cnt_r == sfisr_pkg::LEN_CMD) && (op_r == sfisr_pkg::OP_ID)
         && tx_vld_r;
   endsequence

   a_id_first_bit: assert property (
      @(negedge SCLK_I) disable iff (link_rst)
      s_id_cmd |=> (so_oe_r && (so_r == MFR_ID[7])))
      else $error("id answer did not start at once");

   a_id_busy_block: assert property (
      @(posedge SCLK_I) disable iff (link_rst)
      (busy_l && (bit_cnt_r == sfisr_pkg::SHORT_LAST) &&
       (cmd_nxt == sfisr_pkg::OP_ID)) |=> !tx_vld_r)
      else $error("id decoded while busy");

   a_sig_repeat: assert property (
      @(posedge SCLK_I) disable iff (link_rst)
      (tx_vld_r && (op_r == sfisr_pkg::OP_SIG)) |->
      (tx_r[47:40] == tx_r[31:24]))
      else $error("signature ring broken");

   a_pair_order: assert property (
      @(posedge SCLK_I) disable iff (link_rst)
      (tx_load && (op_r == sfisr_pkg::OP_PAIR) &&
       (cmd_nxt == sfisr_pkg::PAIR_DEV_FIRST)) |=>
      (tx_r[47:40] == MEM_TYPE) ##8 (tx_r[47:40] == MFR_ID))
      else $error("id pair order wrong");

   a_so_release: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      CS_N_I |-> !so_oe_r)
      else $error("output driven while deselected");

   a_wel_gate: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      (pe_start || wsr_start) |-> wel_r ##1 busy_r)
      else $error("write started without latch");

   a_wel_done: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      $fell(busy_r) |-> !wel_r && $past(wel_r))
      else $error("latch not cleared at finish");

   a_prot_drop: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      pe_reject |=> !wel_r && !busy_r)
      else $error("protected command not discarded");

   a_ce_guard: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      (pe_start && is_ce) |-> (bp_r == 4'h0))
      else $error("chip erase with protect set");

   a_hpm_lock: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      (hardware_protected_mode && idle) |=> $stable({status_write_disable_r, bp_r}))
      else $error("locked bits changed");

   a_busy_time: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      wsr_start |=> busy_r[*8])
      else $error("busy dropped too early");

endmodule : sfisr_top

// ---- verification/sfisr_host_model.sv ----
// sfisr_host_model: host controller on the serial link, mode 0, io0 only
// assumes: the link clock runs only inside frames; device answers on so_i
`timescale 1ns/1ns

module sfisr_host_model (
   // serial link
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      si_o,
   input  wire logic so_i,
   input  wire logic so_oe_i
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      si_o   = 1'b0;
   end

   // ntx bits of tx msb first, then nrx answer bits shifted into rx
   task automatic xfer(input logic [39:0] tx, input int ntx, input int nrx,
                       output logic [47:0] rx, output int n_oe);
      rx   = '0;
      n_oe = 0;
      #37 cs_n_o = 1'b0;
      for (int i = 0; i < ntx + nrx; i++) begin
         // past the request the line toggles, never a held value
         si_o = (i < ntx) ? tx[ntx - 1 - i] : ~si_o;
         #62 sclk_o = 1'b1;
         if (i >= ntx) begin
            // a released line reads high, as through a pull-up
            rx   = {rx[46:0], so_oe_i ? so_i : 1'b1};
            n_oe = n_oe + int'(so_oe_i);
         end
         #63 sclk_o = 1'b0;
      end
      #41 cs_n_o = 1'b1;
      si_o = ~si_o;
      // device decodes the finished frame in this gap
      #640;
   endtask : xfer

   // poll busy first, the caller then looks at the latch
   task automatic wait_ready(output logic [7:0] st);
      logic [47:0] rx;
      int          n;
      st = 8'hff;
      for (int k = 0; k < 400 && st[0] !== 1'b0; k++) begin
         xfer(40'(sfisr_pkg::OP_STAT), 8, 8, rx, n);
         st = rx[7:0];
      end
   endtask : wait_ready
endmodule : sfisr_host_model

// ---- verification/testbench.sv ----
// testbench: id, signature, register reads and status bit behaviour
// assumes: sfisr_host_model drives the link; checks are self-contained
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end

module testbench;
   localparam logic [23:0] ID3 = {sfisr_pkg::MFR_ID_DEF,
      sfisr_pkg::MEM_TYPE_DEF, sfisr_pkg::DENSITY_DEF};
   logic        sys_clk, rst, sclk, cs_n, si, so, so_oe, wp_n, hold_n;
   logic        io23_data, hold_act;
   logic [7:0]  status, st;
   logic [47:0] rx;
   logic [15:0] pr;
   int          n_oe, n_errors, n_checks, cycles;

   sfisr_top #(.WSR_CYCLES(16'h00c8)) i_dut (
      .SYS_CLK_I(sys_clk), .RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n),
      .SI_I(si), .SO_O(so), .SO_OE_O(so_oe), .WP_N_I(wp_n),
      .HOLD_N_I(hold_n), .IO23_DATA_MODE_O(io23_data),
      .HOLD_ACTIVE_O(hold_act), .STATUS_O(status));

   sfisr_host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si),
      .so_i(so), .so_oe_i(so_oe));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   // bounded by the longest expected run, with margin
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         n_errors++;
         test_done();
      end
   end

   task automatic cmd(input logic [39:0] tx, input int ntx, input int nrx);
      i_host.xfer(tx, ntx, nrx, rx, n_oe);
   endtask : cmd

   task automatic wsr(input logic [7:0] v);
      cmd(40'(sfisr_pkg::OP_WRITE_ENABLE_CMD), 8, 0);
      cmd(40'({sfisr_pkg::OP_WSR, v}), 16, 0);
   endtask : wsr

   task automatic t_reset();
      `CHK(status, 8'h00)
      `CHK(so_oe, 1'b0)
      `CHK(io23_data, 1'b0)
      cmd(40'(sfisr_pkg::OP_STAT), 8, 16);
      `CHK(rx[15:0], 16'h0000)
      $display("test reset done");
   endtask : t_reset

   task automatic t_ident();
      cmd(40'(sfisr_pkg::OP_ID), 8, 48);
      `CHK(rx, {ID3, ID3})
      `CHK(n_oe, 48)
      cmd(40'(sfisr_pkg::OP_ID), 8, 5);
      `CHK(rx[4:0], ID3[23:19])
      `CHK(so_oe, 1'b0)
      cmd(40'(sfisr_pkg::OP_STAT), 8, 8);
      `CHK(n_oe, 8)
      cmd(40'({sfisr_pkg::OP_SIG, 24'h000000}), 32, 16);
      `CHK(rx[15:0], {2{sfisr_pkg::SIG_DEF}})
      for (int a = 0; a < 2; a++) begin
         cmd(40'({sfisr_pkg::OP_PAIR, 16'h0000, a[0] ?
            sfisr_pkg::PAIR_DEV_FIRST : sfisr_pkg::PAIR_MFR_FIRST}), 32, 32);
         pr = a[0] ? {ID3[15:8], ID3[23:16]} : ID3[23:8];
         `CHK(rx[31:0], {pr, pr})
      end
      $display("test ident done");
   endtask : t_ident

   task automatic t_busy();
      wsr(8'h0f);
      `CHK(status[1:0], 2'b11)
      cmd(40'(sfisr_pkg::OP_STAT), 8, 8);
      `CHK(rx[1:0], 2'b11)
      cmd(40'(sfisr_pkg::OP_ID), 8, 8);
      `CHK(n_oe, 0)
      `CHK(rx[7:0], 8'hff)
      cmd(40'(sfisr_pkg::OP_CFG), 8, 8);
      `CHK(rx[7:0], sfisr_pkg::CFG_RST)
      i_host.wait_ready(st);
      `CHK(st, 8'h0c)
      $display("test busy done");
   endtask : t_busy

   task automatic t_protect();
      cmd(40'(sfisr_pkg::OP_WRITE_ENABLE_CMD), 8, 0);
      cmd(40'({sfisr_pkg::OP_SE, 24'h1f0000}), 32, 0);
      `CHK(status, 8'h0c)
      cmd({sfisr_pkg::OP_PP, 32'h000000a5}, 40, 0);
      `CHK(status, 8'h0c)
      cmd(40'(sfisr_pkg::OP_WRITE_ENABLE_CMD), 8, 0);
      cmd(40'(sfisr_pkg::OP_CE), 8, 0);
      `CHK(status, 8'h0c)
      cmd(40'(sfisr_pkg::OP_WRDI), 8, 0);
      cmd(40'(sfisr_pkg::OP_WRITE_ENABLE_CMD), 8, 0);
      cmd(40'({sfisr_pkg::OP_SE, 24'h000000}), 32, 0);
      `CHK(status[1:0], 2'b11)
      i_host.wait_ready(st);
      `CHK(st, 8'h0c)
      $display("test protect done");
   endtask : t_protect

   task automatic t_lock();
      wsr(8'h8c);
      i_host.wait_ready(st);
      @(negedge sys_clk) wp_n <= 1'b0;
      wsr(8'h00);
      `CHK(status, 8'h8e)
      @(negedge sys_clk) wp_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      cmd(40'({sfisr_pkg::OP_WSR, 8'h00}), 16, 0);
      i_host.wait_ready(st);
      `CHK(status, 8'h00)
      $display("test lock done");
   endtask : t_lock

   task automatic t_quad();
      @(negedge sys_clk) hold_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      `CHK(hold_act, 1'b1)
      wsr(8'hc0);
      i_host.wait_ready(st);
      `CHK(io23_data, 1'b1)
      `CHK(hold_act, 1'b0)
      // quad enable lifts the write-protect lock
      @(negedge sys_clk) wp_n <= 1'b0;
      wsr(8'h00);
      i_host.wait_ready(st);
      `CHK(status, 8'h00)
      `CHK(io23_data, 1'b0)
      `CHK(hold_act, 1'b1)
      @(negedge sys_clk) hold_n <= 1'b1;
      $display("test quad done");
   endtask : t_quad

   // commands run once no protection is left; BE32 on the top block and CE2 only run then
   task automatic t_write();
      cmd(40'(sfisr_pkg::OP_WRITE_ENABLE_CMD), 8, 0);
      cmd(40'({sfisr_pkg::OP_WSR, 8'h00, 8'h48}), 24, 0);
      i_host.wait_ready(st);
      `CHK(st, 8'h00)
      cmd(40'(sfisr_pkg::OP_CFG), 8, 16);
      `CHK(rx[15:0], 16'h4848)
      for (int k = 0; k < 4; k++) begin
         cmd(40'(sfisr_pkg::OP_WRITE_ENABLE_CMD), 8, 0);
         case (k)
            0: cmd({sfisr_pkg::OP_PP, 32'h000000a5}, 40, 0);
            1: cmd(40'({sfisr_pkg::OP_BE, 24'h010000}), 32, 0);
            2: cmd(40'({sfisr_pkg::OP_BE32, 24'h1f0000}), 32, 0);
            default: cmd(40'(sfisr_pkg::OP_CE2), 8, 0);
         endcase
         `CHK(status, 8'h03)
         i_host.wait_ready(st);
         `CHK(st, 8'h00)
      end
      $display("test write done");
   endtask : t_write

   initial begin
      rst = 1'b1;
      wp_n = 1'b1;
      hold_n = 1'b1;
      n_errors = 0;
      n_checks = 0;
      cycles = 0;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk) rst <= 1'b0;
      repeat (3) @(negedge sys_clk);
      t_reset();
      t_ident();
      t_busy();
      t_protect();
      t_lock();
      t_quad();
      t_write();
      test_done();
   end
endmodule : testbench
